//--- verilog/droop_monitor_ctrl.sv
// Supply droop monitor control: AXI4-Lite registers, settle gating,
// sticky low-supply event, interrupt and wake-up from Sleep.
// Assumes the analog comparator drives trip_detect asynchronously and
// that sleep_mode comes from core logic on aclk.
//
// What this block does
// - Detector powered only while the power-on control bit is one.
// - Read-only settled flag at control bit 5, set after each enable settles.
// - No low-supply event before the settled flag is one.
// - Four-bit trip level in control bits 3..0; code 1111 is reserved.
// - Trip while enabled and settled sets the low-supply event flag.
// - Event flag and enable at bit 2; interrupt gated by global bit 7.
// - Settle interval is a fixed absolute time, not clock dependent.
// - Short excursions before settling may be missed.
// - Detector runs in Sleep; a trip sets the flag and, with the event enable set, wakes the core.
// - After wake, vector branch only when interrupts are globally enabled.
// - Any reset restores the control register and powers the detector off.
// - Control bits 7 and 6 read zero and ignore writes.
`timescale 1ns/1ps
module droop_monitor_ctrl #(
  parameter int ADDR_W = 8,
  parameter int SETTLE_CYCLES = droop_pkg::SETTLE_CYCLES
) (
  input wire logic aclk, // 125 MHz clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic trip_detect, // Comparator: supply at trip level
  input wire logic sleep_mode, // Core is in Sleep
  output logic detector_power_on, // Analog detector enable
  output logic [3:0] trip_level_select, // Analog tap select
  output logic irq, // Low-supply interrupt, level
  output logic irq_priority, // High priority when one
  output logic wake_req // Wake the core from Sleep
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic droop_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] a);
    logic [7:0] a8;
    a8 = 8'(a);
    case (a8)
      droop_pkg::ADDR_CONTROL: decode = droop_pkg::SEL_CONTROL;
      droop_pkg::ADDR_FLAGS: decode = droop_pkg::SEL_FLAGS;
      droop_pkg::ADDR_ENABLES: decode = droop_pkg::SEL_ENABLES;
      droop_pkg::ADDR_PRIOS: decode = droop_pkg::SEL_PRIOS;
      droop_pkg::ADDR_CORE_IRQ: decode = droop_pkg::SEL_CORE_IRQ;
      default: decode = droop_pkg::SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wstrb0_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic power_reg;
  logic [3:0] trip_reg;
  logic event_flag_reg;
  logic irq_en_reg;
  logic irq_prio_reg;
  logic global_en_reg;
  logic trip_meta_reg;
  logic trip_sync_reg;
  logic irq_reg;
  logic wake_reg;
  logic commit;
  logic wr_lane;
  droop_pkg::reg_sel_e wr_sel;
  logic settled;
  logic event_hit;
  logic event_clear;
  logic [7:0] ctrl_view;

  settle_if sif ();

  assign sif.power_on = power_reg;
  // Timer flag lags a power-off by one edge; mask it so a read never shows settled while off
  assign settled = sif.settled && power_reg;

  settle_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .sif(sif)
  );

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Commit once both address and data are held and no response pends
  assign commit = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_sel = decode(awaddr_reg);
  assign wr_lane = commit && wstrb0_reg;

  // Address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= '0;
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b1;
    end else if (s_axi_awvalid && awready_reg) begin
      awaddr_reg <= s_axi_awaddr;
      aw_held_reg <= 1'b1;
      awready_reg <= 1'b0;
    end else if (commit) begin
      aw_held_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
    end
  end

  // Data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wready_reg <= 1'b1;
    end else if (s_axi_wvalid && wready_reg) begin
      wdata_reg <= s_axi_wdata;
      wstrb0_reg <= s_axi_wstrb[0];
      w_held_reg <= 1'b1;
      wready_reg <= 1'b0;
    end else if (commit) begin
      w_held_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
    end
  end

  // Response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= droop_pkg::RESP_OKAY;
    end else if (commit) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == droop_pkg::SEL_NONE) ? droop_pkg::RESP_SLVERR : droop_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Reset powers the detector off; bits 7..5 are not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_reg <= 1'b0;
      trip_reg <= droop_pkg::TRIP_RESET;
    end else if (wr_lane && wr_sel == droop_pkg::SEL_CONTROL) begin
      power_reg <= wdata_reg[droop_pkg::POWER_BIT];
      // Reserved code keeps the old level rather than select no tap
      if (wdata_reg[droop_pkg::TRIP_MSB:0] != droop_pkg::TRIP_RESERVED) begin
        trip_reg <= wdata_reg[droop_pkg::TRIP_MSB:0];
      end
    end
  end

  // Enable, priority and global enable bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_reg <= 1'b0;
      irq_prio_reg <= 1'b0;
      global_en_reg <= 1'b0;
    end else if (wr_lane) begin
      if (wr_sel == droop_pkg::SEL_ENABLES) begin
        irq_en_reg <= wdata_reg[droop_pkg::EVENT_BIT];
      end
      if (wr_sel == droop_pkg::SEL_PRIOS) begin
        irq_prio_reg <= wdata_reg[droop_pkg::EVENT_BIT];
      end
      if (wr_sel == droop_pkg::SEL_CORE_IRQ) begin
        global_en_reg <= wdata_reg[droop_pkg::GLOBAL_BIT];
      end
    end
  end

  // ----------------------------------------
  // Trip input and event flag
  // ----------------------------------------
  // Comparator is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_meta_reg <= 1'b0;
      trip_sync_reg <= 1'b0;
    end else begin
      trip_meta_reg <= trip_detect;
      trip_sync_reg <= trip_meta_reg;
    end
  end

  // Events before settling are blocked and so may be missed
  assign event_hit = trip_sync_reg && power_reg && settled;
  assign event_clear = wr_lane && wr_sel == droop_pkg::SEL_FLAGS && wdata_reg[droop_pkg::EVENT_BIT];

  // Sticky flag, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_flag_reg <= 1'b0;
    end else if (event_hit) begin
      event_flag_reg <= 1'b1;
    end else if (event_clear) begin
      event_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt and wake-up
  // ----------------------------------------
  // Wake needs only the local enable; vectoring also needs the global one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= event_flag_reg && irq_en_reg && global_en_reg;
      wake_reg <= event_flag_reg && irq_en_reg && sleep_mode;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  // Bits 7 and 6 of control always read zero
  assign ctrl_view = {2'b00, settled, power_reg, trip_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= droop_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= droop_pkg::RESP_OKAY;
      rdata_reg <= '0;
      case (decode(s_axi_araddr))
        droop_pkg::SEL_CONTROL: rdata_reg[7:0] <= ctrl_view;
        droop_pkg::SEL_FLAGS: rdata_reg[droop_pkg::EVENT_BIT] <= event_flag_reg;
        droop_pkg::SEL_ENABLES: rdata_reg[droop_pkg::EVENT_BIT] <= irq_en_reg;
        droop_pkg::SEL_PRIOS: rdata_reg[droop_pkg::EVENT_BIT] <= irq_prio_reg;
        droop_pkg::SEL_CORE_IRQ: rdata_reg[droop_pkg::GLOBAL_BIT] <= global_en_reg;
        default: rresp_reg <= droop_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign detector_power_on = power_reg;
  assign trip_level_select = trip_reg;
  assign irq = irq_reg;
  assign irq_priority = irq_prio_reg;
  assign wake_req = wake_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_power_write;
    wr_lane && wr_sel == droop_pkg::SEL_CONTROL |=>
      detector_power_on == $past(wdata_reg[droop_pkg::POWER_BIT]);
  endproperty
  a_power_write: assert property (p_power_write) else $error("power bit not applied");

  property p_settled_powered;
    settled |-> detector_power_on && $past(detector_power_on);
  endproperty
  a_settled_powered: assert property (p_settled_powered) else $error("settled while off");

  property p_no_early_event;
    $rose(event_flag_reg) |-> $past(settled) && $past(power_reg);
  endproperty
  a_no_early_event: assert property (p_no_early_event) else $error("event before settle");

  property p_no_reserved;
    trip_level_select != droop_pkg::TRIP_RESERVED;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved trip code");

  property p_event_set;
    trip_sync_reg && power_reg && settled |=> event_flag_reg;
  endproperty
  a_event_set: assert property (p_event_set) else $error("event lost");

  property p_irq_gate;
    event_flag_reg && irq_en_reg |=> irq == $past(global_en_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

  property p_wake;
    wake_req == $past(sleep_mode && event_flag_reg && irq_en_reg);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake in sleep");

  property p_reset_off;
    disable iff (1'b0) !aresetn |=> !detector_power_on && trip_level_select == droop_pkg::TRIP_RESET;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset state wrong");

  property p_sticky;
    event_flag_reg && !event_clear |=> event_flag_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

endmodule // droop_monitor_ctrl

//--- verilog/droop_pkg.sv
// Constants shared by the supply droop monitor control logic.
// Assumes a 125 MHz aclk and an AXI4-Lite register port.
package droop_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_ENABLES = 8'h08;
  localparam logic [7:0] ADDR_PRIOS = 8'h0c;
  localparam logic [7:0] ADDR_CORE_IRQ = 8'h10;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SETTLED_BIT = 5;
  localparam int POWER_BIT = 4;
  localparam int TRIP_MSB = 3;
  localparam int EVENT_BIT = 2;
  localparam int GLOBAL_BIT = 7;
  localparam logic [3:0] TRIP_RESET = 4'h5;
  localparam logic [3:0] TRIP_RESERVED = 4'hf;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Settle interval, absolute time turned into cycles
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SETTLE_TIME_NS = 20000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Register selected by an address
  typedef enum logic [2:0] {
    SEL_CONTROL = 3'b000,
    SEL_FLAGS = 3'b001,
    SEL_ENABLES = 3'b010,
    SEL_PRIOS = 3'b011,
    SEL_CORE_IRQ = 3'b100,
    SEL_NONE = 3'b111
  } reg_sel_e;

endpackage

//--- verilog/settle_if.sv
// Handshake between control logic and the reference settle timer.
// Both ends share aclk.
`timescale 1ns/1ps
interface settle_if;
  logic power_on; // Detector powered
  logic settled; // Reference stable

  modport ctrl (output power_on, input settled);
  modport timer (input power_on, output settled);
endinterface

//--- verilog/settle_timer.sv
// Reference settle timer: counts a fixed absolute time after power-on.
// Assumes power_on comes from a flop on the same aclk.
`timescale 1ns/1ps
module settle_timer #(
  parameter int SETTLE_CYCLES = droop_pkg::SETTLE_CYCLES
) (
  input wire logic aclk, // 125 MHz clock
  input wire logic aresetn, // Sync reset, active low
  settle_if.timer sif // Power in, settled out
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic settled_reg;

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  // Restarts on every enable, so each power-up waits the full time
  always_ff @(posedge aclk) begin
    if (!aresetn || !sif.power_on) begin
      count_reg <= '0;
    end else if (count_reg != LAST) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  // Settled flag, dropped on the edge after power goes away
  always_ff @(posedge aclk) begin
    if (!aresetn || !sif.power_on) begin
      settled_reg <= 1'b0;
    end else if (count_reg == LAST) begin
      settled_reg <= 1'b1;
    end
  end

  assign sif.settled = settled_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_settle_count;
    @(posedge aclk) disable iff (!aresetn)
    $rose(settled_reg) |-> $past(count_reg) == LAST && $past(sif.power_on);
  endproperty
  a_settle_count: assert property (p_settle_count) else $error("settled early");

  property p_power_drop;
    @(posedge aclk) disable iff (!aresetn)
    !sif.power_on |=> !settled_reg;
  endproperty
  a_power_drop: assert property (p_power_drop) else $error("settled kept");

endmodule // settle_timer

//--- verification/tb_top.sv
// Self-checking bench for the supply droop monitor control block.
// Assumes the design files are compiled first; drives AXI4-Lite and pins directly.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals and bench model
  // ----------------------------------------
  localparam int SC = 12; // Short settle count keeps the run brief
  logic aclk, aresetn, trip_detect, sleep_mode;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, trip_level_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic detector_power_on, irq, irq_priority, wake_req;
  int bad_count, checks_done;
  int m_trip, m_pwr, m_set, m_flag, m_en, m_prio, m_glob;

  droop_monitor_ctrl #(.ADDR_W(8), .SETTLE_CYCLES(SC)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trip_detect(trip_detect),
    .sleep_mode(sleep_mode), .detector_power_on(detector_power_on),
    .trip_level_select(trip_level_select), .irq(irq), .irq_priority(irq_priority),
    .wake_req(wake_req)
  );

  // ----------------------------------------
  // Clock, watchdog, closing
  // ----------------------------------------
  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Whole sequence needs about 330 cycles; allow plenty more
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    wrap_up();
  end

  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait n edges, then step off the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // Expected register contents from the model
  function automatic logic [31:0] mexp(input logic [7:0] a);
    case (a)
      droop_pkg::ADDR_CONTROL: mexp = 32'(m_set * 32 + m_pwr * 16 + m_trip);
      droop_pkg::ADDR_FLAGS: mexp = 32'(m_flag * 4);
      droop_pkg::ADDR_ENABLES: mexp = 32'(m_en * 4);
      droop_pkg::ADDR_PRIOS: mexp = 32'(m_prio * 4);
      droop_pkg::ADDR_CORE_IRQ: mexp = 32'(m_glob * 128);
      default: mexp = 32'h0;
    endcase
  endfunction

  // Handshakes are seen at the falling edge, released at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit ha, hw, hb;
    int n;
    n = 0;
    hb = 0;
    r = 2'bxx;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb && n < 100) begin
      @(negedge aclk);
      ha = s_axi_awvalid && (s_axi_awready === 1'b1);
      hw = s_axi_wvalid && (s_axi_wready === 1'b1);
      hb = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
      n++;
    end
    chk("bresp", er, hb ? r : 2'bxx);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic [1:0] r;
    logic [31:0] d;
    bit ha, hr;
    int n;
    n = 0;
    hr = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr && n < 100) begin
      @(negedge aclk);
      ha = s_axi_arvalid && (s_axi_arready === 1'b1);
      hr = (s_axi_rvalid === 1'b1);
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
      n++;
    end
    chk("rresp", er, hr ? r : 2'bxx);
    chk("rdata", mexp(a), hr ? d : 32'hx);
  endtask

  // Control write with model update; reserved trip code leaves the level alone
  task automatic wctl(input logic [31:0] d);
    wr(droop_pkg::ADDR_CONTROL, d, droop_pkg::RESP_OKAY);
    m_pwr = int'(d[4]);
    if (d[3:0] != 4'hf) m_trip = int'(d[3:0]);
    if (m_pwr == 0) m_set = 0;
  endtask

  task automatic pulse(input int n);
    @(posedge aclk);
    trip_detect <= 1'b1;
    cyc(n);
    @(posedge aclk);
    trip_detect <= 1'b0;
  endtask

  task automatic mreset();
    m_trip = 5;
    {m_pwr, m_set, m_flag, m_en, m_prio, m_glob} = '0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, trip_detect, sleep_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    checks_done = 0;
    mreset();
    void'($urandom(69));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 20; a += 4) rd(8'(a), droop_pkg::RESP_OKAY);
    chk("power_port", 32'h0, detector_power_on);
    // Every trip code, with random writes to the dead upper bits
    for (int i = 0; i < 16; i++) begin
      wctl(($urandom & 32'he0) | 32'(i));
      rd(droop_pkg::ADDR_CONTROL, droop_pkg::RESP_OKAY);
      chk("trip_port", 32'(m_trip), trip_level_select);
    end
    // Brief excursion right after power-on must be lost
    wctl(32'h13);
    pulse(2);
    rd(droop_pkg::ADDR_CONTROL, droop_pkg::RESP_OKAY);
    cyc(SC * 3);
    m_set = 1;
    rd(droop_pkg::ADDR_FLAGS, droop_pkg::RESP_OKAY);
    rd(droop_pkg::ADDR_CONTROL, droop_pkg::RESP_OKAY);
    chk("power_port", 32'h1, detector_power_on);
    // Settled trip sets a sticky flag
    pulse(3);
    cyc(8);
    m_flag = 1;
    rd(droop_pkg::ADDR_FLAGS, droop_pkg::RESP_OKAY);
    chk("irq_masked", 32'h0, irq);
    wr(droop_pkg::ADDR_ENABLES, 32'h4, droop_pkg::RESP_OKAY);
    m_en = 1;
    cyc(3);
    chk("irq_no_global", 32'h0, irq);
    chk("wake_awake", 32'h0, wake_req);
    @(posedge aclk);
    sleep_mode <= 1'b1;
    cyc(3);
    chk("wake_sleep", 32'h1, wake_req);
    chk("irq_sleep_no_global", 32'h0, irq);
    wr(droop_pkg::ADDR_CORE_IRQ, 32'h80, droop_pkg::RESP_OKAY);
    m_glob = 1;
    cyc(3);
    chk("irq_on", 32'h1, irq);
    wr(droop_pkg::ADDR_PRIOS, 32'h4, droop_pkg::RESP_OKAY);
    m_prio = 1;
    cyc(3);
    chk("prio_port", 32'h1, irq_priority);
    rd(droop_pkg::ADDR_PRIOS, droop_pkg::RESP_OKAY);
    rd(droop_pkg::ADDR_FLAGS, droop_pkg::RESP_OKAY);
    wr(droop_pkg::ADDR_FLAGS, 32'h4, droop_pkg::RESP_OKAY);
    m_flag = 0;
    cyc(3);
    chk("irq_cleared", 32'h0, irq);
    chk("wake_cleared", 32'h0, wake_req);
    rd(droop_pkg::ADDR_FLAGS, droop_pkg::RESP_OKAY);
    // Trip while asleep raises both wake and interrupt
    pulse(3);
    cyc(8);
    m_flag = 1;
    chk("wake_trip", 32'h1, wake_req);
    chk("irq_trip", 32'h1, irq);
    wr(droop_pkg::ADDR_ENABLES, 32'h0, droop_pkg::RESP_OKAY);
    m_en = 0;
    cyc(3);
    chk("irq_mask_off", 32'h0, irq);
    wr(droop_pkg::ADDR_FLAGS, 32'h4, droop_pkg::RESP_OKAY);
    m_flag = 0;
    // Power off drops settled and blocks events
    wctl(32'h03);
    chk("power_port", 32'h0, detector_power_on);
    rd(droop_pkg::ADDR_CONTROL, droop_pkg::RESP_OKAY);
    pulse(3);
    cyc(8);
    rd(droop_pkg::ADDR_FLAGS, droop_pkg::RESP_OKAY);
    // Write with lane 0 disabled must leave control alone
    s_axi_wstrb <= 4'he;
    wr(droop_pkg::ADDR_CONTROL, 32'h1f, droop_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(droop_pkg::ADDR_CONTROL, droop_pkg::RESP_OKAY);
    // Unmapped place refuses
    wr(8'h14, $urandom, droop_pkg::RESP_SLVERR);
    rd(8'h14, droop_pkg::RESP_SLVERR);
    // Reset in mid-run turns the detector off
    wctl(32'h1a);
    @(posedge aclk);
    sleep_mode <= 1'b0;
    aresetn <= 1'b0;
    cyc(2);
    @(posedge aclk);
    aresetn <= 1'b1;
    mreset();
    rd(droop_pkg::ADDR_CONTROL, droop_pkg::RESP_OKAY);
    rd(droop_pkg::ADDR_CORE_IRQ, droop_pkg::RESP_OKAY);
    cyc(1);
    chk("power_port", 32'h0, detector_power_on);
    wrap_up();
  end
endmodule // tb_top
